// file: pkg/msc_pkg.sv
// msc_pkg: constants and types of the superframe power state controller.
// assumes a 40 mhz system clock; all times are given in ns.
package msc_pkg;

  // power management mode of the current superframe
  typedef enum logic [1:0]
  {
    MSC_ACTIVE    = 2'b00,
    MSC_ANNOUNCE  = 2'b01,
    MSC_HIBERNATE = 2'b10
  } msc_mode_type;

  localparam int CLK_NS       = 25;
  // access-delay parts; plain defaults, set to the phy in use
  localparam int MAX_FRAME_NS = 640000;
  localparam int IMM_ACK_NS   = 20000;
  localparam int SIFS_NS      = 10000;
  localparam int ACC_DELAY_NS = MAX_FRAME_NS + IMM_ACK_NS + SIFS_NS;

  localparam int NUM_MAS      = 256;
  localparam int CNT_W        = 8;

  // reset values and the count step
  localparam logic             RST_AWAKE  = 1'b1;
  localparam logic             RST_MORE   = 1'b0;
  localparam logic [CNT_W-1:0] RST_CNT    = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE    = 8'h01;

endpackage

// file: verilog/msc_access_delay.sv
// msc_access_delay: channel sensing timer run after a wake-up.
// assumes start and hdr_rx are synchronous one-cycle pulses and abort a synchronous level.
`timescale 1ns/10ps
module msc_access_delay
#(
  parameter int DELAY_CYC = 27600
)
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic start,
  input  wire logic abort,
  input  wire logic hdr_rx,
  output logic      sensing_ff,
  output logic      done_ff
);

  localparam int CW = $clog2(DELAY_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY_CYC - 1);
  localparam logic [CW-1:0] ZERO = '0;

  logic [CW-1:0] cnt_ff;
  wire           expire = sensing_ff & ((cnt_ff == LAST) | hdr_rx);

  // counts the full delay unless a frame header or an abort ends it early
  always_ff @(posedge clk)
  begin
    if (sys_rst | abort)
    begin
      sensing_ff <= 1'b0;
      done_ff    <= 1'b0;
      cnt_ff     <= ZERO;
    end
    else if (start)
    begin
      sensing_ff <= 1'b1;
      done_ff    <= 1'b0;
      cnt_ff     <= ZERO;
    end
    else if (expire)
    begin
      sensing_ff <= 1'b0;
      done_ff    <= 1'b1;
    end
    else if (sensing_ff)
    begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

endmodule // msc_access_delay

// file: verilog/msc_power_ctrl.sv
// msc_power_ctrl: per-superframe mode and awake/sleep sequencing of a mac.
// assumes a mac timebase that pulses superframe, beacon period and mas
// boundaries, and traffic flags from the frame engines, all synchronous.
// Notes on behaviour
// - each superframe is active (beacons sent) or hibernation (nothing sent).
// - hibernation is announced in at least one earlier superframe.
// - in active mode the device is either awake or asleep.
// - after waking with contention traffic queued, sense the channel first.
// - sensing lasts one longest frame plus an ack plus the short gap.
// - awake from the guard time before each beacon period start.
// - awake before own tx reservation blocks; may sleep once sending is done.
// - release the reservation block before sleeping inside it.
// - more frames is zero on the last frame sent in a block.
// - pending contention tx is advertised; sleep allowed after finishing.
// - more frames is zero on last contention frame to each recipient.
// - awake from guard time before blocks that peers send to us.
// - receiving in a block may sleep at block end or after last frame.
// - after an unused-drp announcement, stay awake until the response is sent.
// - with availability advertised, awake from guard before listed mas.
// - without availability advertised, awake through all contention mas.
// - after the last contention frame arrives, may sleep for the superframe.
// - countdown reaching zero starts hibernation at the next superframe.
`timescale 1ns/10ps
module msc_power_ctrl
#(
  parameter int NUM_MAS      = msc_pkg::NUM_MAS,
  parameter int ACC_DELAY_NS = msc_pkg::ACC_DELAY_NS
)
(
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // timebase
  input  wire logic                      sf_start,
  input  wire logic                      bp_guard,
  input  wire logic                      bp_end,
  input  wire logic                      mas_guard,
  input  wire logic [$clog2(NUM_MAS)-1:0] mas_guard_idx,
  input  wire logic                      mas_start,
  input  wire logic [$clog2(NUM_MAS)-1:0] mas_idx,
  // mas maps of this superframe
  input  wire logic [NUM_MAS-1:0]        drp_tx_map,
  input  wire logic [NUM_MAS-1:0]        drp_rx_map,
  input  wire logic [NUM_MAS-1:0]        pca_open_map,
  input  wire logic [NUM_MAS-1:0]        pca_avail_map,
  input  wire logic                      pca_avail_adv,
  // traffic
  input  wire logic                      drp_tx_pend,
  input  wire logic                      drp_tx_done,
  input  wire logic                      drp_rx_last,
  input  wire logic                      pca_tx_pend,
  input  wire logic                      pca_rx_expect,
  input  wire logic                      pca_rx_last,
  input  wire logic                      uda_rx,
  input  wire logic                      udr_tx,
  input  wire logic                      hdr_rx,
  input  wire logic                      tx_frame,
  input  wire logic                      tx_last_blk,
  input  wire logic                      tx_last_pca,
  // hibernation control
  input  wire logic                      hib_req,
  input  wire logic [msc_pkg::CNT_W-1:0] hib_cnt_in,
  input  wire logic [msc_pkg::CNT_W-1:0] hib_dur_in,
  input  wire logic                      hib_exit,
  // status
  output logic                           awake_ff,
  output logic                           beacon_en_ff,
  output logic                           hib_ie_ff,
  output logic [msc_pkg::CNT_W-1:0]      hib_count_ff,
  output logic                           tim_ie_ff,
  output logic                           release_ff,
  output logic                           more_frames_ff,
  output logic                           sensing_ff,
  output logic                           pca_grant_ff
);

  localparam int MW      = $clog2(NUM_MAS);
  // least time, so round up to whole cycles
  localparam int ACC_CYC = (ACC_DELAY_NS + msc_pkg::CLK_NS - 1) / msc_pkg::CLK_NS;

  // one bit of a mas map, used by every window test
  function automatic logic bit_at(input logic [NUM_MAS-1:0] m, input logic [MW-1:0] i);
    bit_at = m[i];
  endfunction

  msc_pkg::msc_mode_type     mode_ff;
  msc_pkg::msc_mode_type     nxt_mode;
  logic [msc_pkg::CNT_W-1:0] hib_dur_ff;
  logic [msc_pkg::CNT_W-1:0] nxt_count;
  logic [msc_pkg::CNT_W-1:0] nxt_dur;
  logic                      bp_win_ff;
  logic                      in_mas_ff;
  logic [MW-1:0]             cur_mas_ff;
  logic                      guard_ff;
  logic [MW-1:0]             gmas_ff;
  logic                      txb_done_ff;
  logic                      rxb_done_ff;
  logic                      uda_ff;
  logic                      pcarx_done_ff;
  logic                      acc_done;

  // window of a map: inside a listed mas, or in the guard ahead of one;
  // the guard pulse itself counts so the radio is up at the clock edge that samples it
  wire win_tx    = (in_mas_ff & bit_at(drp_tx_map, cur_mas_ff)) |
                   (guard_ff & bit_at(drp_tx_map, gmas_ff)) |
                   (mas_guard & bit_at(drp_tx_map, mas_guard_idx));
  wire win_rx    = (in_mas_ff & bit_at(drp_rx_map, cur_mas_ff)) |
                   (guard_ff & bit_at(drp_rx_map, gmas_ff)) |
                   (mas_guard & bit_at(drp_rx_map, mas_guard_idx));
  wire win_avail = (in_mas_ff & bit_at(pca_avail_map, cur_mas_ff)) |
                   (guard_ff & bit_at(pca_avail_map, gmas_ff)) |
                   (mas_guard & bit_at(pca_avail_map, mas_guard_idx));
  wire in_open   = in_mas_ff & bit_at(pca_open_map, cur_mas_ff);
  wire in_txblk  = in_mas_ff & bit_at(drp_tx_map, cur_mas_ff);
  wire in_rxblk  = in_mas_ff & bit_at(drp_rx_map, cur_mas_ff);

  // block ends when the next mas is outside it
  wire txb_end   = sf_start | (mas_start & ~bit_at(drp_tx_map, mas_idx));
  wire rxb_end   = sf_start | (mas_start & ~bit_at(drp_rx_map, mas_idx));

  // reasons to stay awake
  wire hold_tx    = drp_tx_pend & ~txb_done_ff & win_tx;
  wire hold_rx    = ~rxb_done_ff & win_rx;
  wire hold_pctx  = pca_tx_pend & in_open;
  wire pcarx_win  = pca_avail_adv ? win_avail : in_open;
  wire hold_pcrx  = pca_rx_expect & ~pcarx_done_ff & pcarx_win;
  wire active     = (mode_ff != msc_pkg::MSC_HIBERNATE);
  wire bp_win     = bp_guard | bp_win_ff;
  wire nxt_awake  = active & (bp_win | hold_tx | hold_rx | uda_ff |
                    hold_pctx | hold_pcrx);

  // last cycle asleep before the wake edge, with contention frames queued
  wire wake_rise  = nxt_awake & ~awake_ff & pca_tx_pend;
  wire sleep_now  = ~nxt_awake;
  wire release_ev = drp_tx_done & in_txblk & ~txb_done_ff;

  // mode sequencing at superframe start
  always_comb
  begin
    nxt_mode  = mode_ff;
    nxt_count = hib_count_ff;
    nxt_dur   = hib_dur_ff;
    if (sf_start)
    begin
      unique case (mode_ff)
        msc_pkg::MSC_ACTIVE:
        begin
          if (hib_req)
          begin
            nxt_mode  = msc_pkg::MSC_ANNOUNCE;
            nxt_count = hib_cnt_in;
          end
        end
        msc_pkg::MSC_ANNOUNCE:
        begin
          if (hib_count_ff == msc_pkg::RST_CNT)
          begin
            nxt_mode = msc_pkg::MSC_HIBERNATE;
            nxt_dur  = hib_dur_in;
          end
          else
          begin
            nxt_count = hib_count_ff - msc_pkg::CNT_ONE;
          end
        end
        msc_pkg::MSC_HIBERNATE:
        begin
          // a zero duration is illegal; treat it as a single superframe
          if (hib_exit | (hib_dur_ff <= msc_pkg::CNT_ONE))
          begin
            nxt_mode  = msc_pkg::MSC_ACTIVE;
            nxt_count = msc_pkg::RST_CNT;
          end
          nxt_dur = hib_dur_ff - msc_pkg::CNT_ONE;
        end
        default:
        begin
          nxt_mode = msc_pkg::MSC_ACTIVE;
        end
      endcase
    end
  end

  // mode and beacon registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode_ff      <= msc_pkg::MSC_ACTIVE;
      hib_count_ff <= msc_pkg::RST_CNT;
      hib_dur_ff   <= msc_pkg::RST_CNT;
      beacon_en_ff <= 1'b1;
      hib_ie_ff    <= 1'b0;
    end
    else
    begin
      mode_ff      <= nxt_mode;
      hib_count_ff <= nxt_count;
      hib_dur_ff   <= nxt_dur;
      beacon_en_ff <= (nxt_mode != msc_pkg::MSC_HIBERNATE);
      hib_ie_ff    <= (nxt_mode == msc_pkg::MSC_ANNOUNCE);
    end
  end

  // timebase tracking; set wins where pulses meet
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bp_win_ff  <= 1'b0;
      in_mas_ff  <= 1'b0;
      cur_mas_ff <= '0;
      guard_ff   <= 1'b0;
      gmas_ff    <= '0;
    end
    else
    begin
      bp_win_ff <= bp_guard | (bp_win_ff & ~bp_end);
      in_mas_ff <= mas_start | (in_mas_ff & ~sf_start);
      guard_ff  <= mas_guard | (guard_ff & ~mas_start);
      if (mas_start)
      begin
        cur_mas_ff <= mas_idx;
      end
      if (mas_guard)
      begin
        gmas_ff <= mas_guard_idx;
      end
    end
  end

  // completion flags; a new completion beats the block end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      txb_done_ff   <= 1'b0;
      rxb_done_ff   <= 1'b0;
      pcarx_done_ff <= 1'b0;
      uda_ff        <= 1'b0;
    end
    else
    begin
      txb_done_ff   <= (drp_tx_done & in_txblk) | (txb_done_ff & ~txb_end);
      rxb_done_ff   <= (drp_rx_last & in_rxblk) | (rxb_done_ff & ~rxb_end);
      pcarx_done_ff <= pca_rx_last | (pcarx_done_ff & ~sf_start);
      uda_ff        <= uda_rx | (uda_ff & ~udr_tx);
    end
  end

  // awake state and beacon content
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      awake_ff  <= msc_pkg::RST_AWAKE;
      tim_ie_ff <= 1'b0;
      release_ff <= 1'b0;
    end
    else
    begin
      awake_ff   <= nxt_awake;
      release_ff <= release_ev;
      if (sf_start)
      begin
        tim_ie_ff <= pca_tx_pend & (nxt_mode != msc_pkg::MSC_HIBERNATE);
      end
      else if (pca_tx_pend & active)
      begin
        tim_ie_ff <= 1'b1;
      end
    end
  end

  // more frames follows the frame being handed to the phy
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      more_frames_ff <= msc_pkg::RST_MORE;
    end
    else if (tx_frame)
    begin
      more_frames_ff <= ~(tx_last_blk | tx_last_pca);
    end
  end

  // channel sensing after wake-up; sleeping cancels it
  msc_access_delay
  #(
    .DELAY_CYC (ACC_CYC)
  )
  u_acc
  (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .start      (wake_rise),
    .abort      (sleep_now),
    .hdr_rx     (hdr_rx),
    .sensing_ff (sensing_ff),
    .done_ff    (acc_done)
  );

  // contention transmit only after the medium state is known
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pca_grant_ff <= 1'b0;
    end
    else
    begin
      pca_grant_ff <= acc_done & nxt_awake & pca_tx_pend;
    end
  end

endmodule // msc_power_ctrl

// file: sim/msc_power_ctrl_asserts.sv
// checker: power state relations seen at the controller ports
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/10ps
module msc_power_ctrl_asserts
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       sf_start,
  input wire logic       bp_guard,
  input wire logic       awake_ff,
  input wire logic       beacon_en_ff,
  input wire logic       hib_ie_ff,
  input wire logic [7:0] hib_count_ff,
  input wire logic       tim_ie_ff,
  input wire logic       release_ff,
  input wire logic       sensing_ff,
  input wire logic       pca_grant_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // last announced superframe, countdown already spent
  sequence s_last_ann;
    sf_start && hib_ie_ff && hib_count_ff == 8'h00;
  endsequence
  // sensing ends while the radio is still up
  sequence s_sense_end;
    $fell(sensing_ff) && awake_ff;
  endsequence
  // mode, countdown and wake relations
  property p_quiet; !beacon_en_ff |-> !awake_ff && !tim_ie_ff; endproperty
  a_quiet: assert property (p_quiet) else $error("activity in hibernation");
  property p_mode_hold; !sf_start |=> $stable(beacon_en_ff); endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed mid superframe");
  property p_announce; $fell(beacon_en_ff) |-> $past(hib_ie_ff); endproperty
  a_announce: assert property (p_announce) else $error("hibernation not announced");
  property p_count; sf_start && hib_ie_ff && hib_count_ff != 8'h00 |=> hib_count_ff == $past(hib_count_ff) - 8'h01; endproperty
  a_count: assert property (p_count) else $error("countdown not decremented");
  property p_enter; s_last_ann |=> !beacon_en_ff && !hib_ie_ff; endproperty
  a_enter: assert property (p_enter) else $error("hibernation not entered");
  property p_guard; bp_guard && beacon_en_ff && !sf_start |=> awake_ff; endproperty
  a_guard: assert property (p_guard) else $error("asleep after beacon guard");
  property p_sense; $rose(sensing_ff) |-> awake_ff; endproperty
  a_sense: assert property (p_sense) else $error("sensing without wake");
  property p_grant; s_sense_end |-> ##[0:1] pca_grant_ff; endproperty
  a_grant: assert property (p_grant) else $error("no access after sensing");
  property p_release; release_ff |-> awake_ff; endproperty
  a_release: assert property (p_release) else $error("release while asleep");
endmodule // msc_power_ctrl_asserts

bind msc_power_ctrl msc_power_ctrl_asserts msc_power_ctrl_asserts_inst (.clk, .sys_rst, .sf_start, .bp_guard,
  .awake_ff, .beacon_en_ff, .hib_ie_ff, .hib_count_ff, .tim_ie_ff, .release_ff, .sensing_ff, .pca_grant_ff);

// file: sim/msc_peer_model.sv
// peer mac: sends one frame header a fixed gap after a request
// assumes go is a one-cycle pulse on clk
`timescale 1ns/10ps
module msc_peer_model
#(
  parameter int GAP = 10
)
(
  input  wire logic clk,
  input  wire logic go,
  output logic      hdr_rx = 1'b0
);
  int cnt = 0;
  // header is a single-cycle pulse, never held
  always @(posedge clk)
  begin
    cnt <= go ? GAP : (cnt > 0 ? cnt - 1 : 0);
    hdr_rx <= (cnt == 1);
  end
endmodule // msc_peer_model

// file: sim/msc_power_ctrl_tb.sv
// testbench of the superframe power state controller
// assumes package, design, checker and peer model compiled first
`timescale 1ns/10ps
module msc_power_ctrl_tb;
  // short access delay keeps the run brief
  localparam int ACC_NS = 2500;
  localparam int ACC_CYC = ACC_NS / msc_pkg::CLK_NS;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sf_start, bp_guard, bp_end, mas_guard, mas_start, pca_avail_adv, drp_tx_pend, drp_tx_done;
  logic drp_rx_last, pca_tx_pend, pca_rx_expect, pca_rx_last, uda_rx, udr_tx, tx_frame, tx_last_blk;
  logic tx_last_pca, hib_req, hib_exit, peer_go, hdr_rx;
  logic [7:0] mas_guard_idx, mas_idx, hib_cnt_in, hib_dur_in, hib_count_ff;
  logic [255:0] drp_tx_map, drp_rx_map, pca_open_map, pca_avail_map;
  logic awake_ff, beacon_en_ff, hib_ie_ff, tim_ie_ff, release_ff, more_frames_ff, sensing_ff, pca_grant_ff;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;

  msc_power_ctrl #(.NUM_MAS(256), .ACC_DELAY_NS(ACC_NS)) msc_power_ctrl_inst
  (
    .clk, .sys_rst, .sf_start, .bp_guard, .bp_end, .mas_guard, .mas_guard_idx, .mas_start, .mas_idx,
    .drp_tx_map, .drp_rx_map, .pca_open_map, .pca_avail_map, .pca_avail_adv, .drp_tx_pend, .drp_tx_done,
    .drp_rx_last, .pca_tx_pend, .pca_rx_expect, .pca_rx_last, .uda_rx, .udr_tx, .hdr_rx, .tx_frame,
    .tx_last_blk, .tx_last_pca, .hib_req, .hib_cnt_in, .hib_dur_in, .hib_exit, .awake_ff, .beacon_en_ff,
    .hib_ie_ff, .hib_count_ff, .tim_ie_ff, .release_ff, .more_frames_ff, .sensing_ff, .pca_grant_ff
  );
  msc_peer_model #(.GAP(10)) msc_peer_model_inst (.clk, .go(peer_go), .hdr_rx);

  // inputs move on the falling edge only
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // wake at beacon guard, full sensing time, then access
  task t_wake;
    int n;
    // sensing rises with the wake edge, one sensing cycle already seen
    n = 1;
    pca_tx_pend = 1'b1;
    pulse(bp_guard);
    chk(awake_ff, 8'h01);
    tick(1);
    chk(sensing_ff, 8'h01);
    while (sensing_ff === 1'b1 && n < 400)
    begin
      tick(1);
      n++;
    end
    chk(8'(n), 8'(ACC_CYC));
    tick(1);
    chk(pca_grant_ff, 8'h01);
    pca_tx_pend = 1'b0;
    pulse(bp_end);
    tick(1);
    chk(awake_ff, 8'h00);
  endtask
  // a peer header cuts sensing short
  task t_hdr;
    pca_tx_pend = 1'b1;
    pulse(bp_guard);
    pulse(peer_go);
    chk(sensing_ff, 8'h01);
    tick(14);
    chk(sensing_ff, 8'h00);
    pca_tx_pend = 1'b0;
    pulse(bp_end);
    tick(1);
  endtask
  // own reservation block: wake at guard, release before sleep
  task t_drp;
    drp_tx_map = '1;
    drp_tx_pend = 1'b1;
    mas_guard_idx = 8'h05;
    mas_idx = 8'h05;
    pulse(mas_guard);
    tick(1);
    chk(awake_ff, 8'h01);
    pulse(mas_start);
    pulse(drp_tx_done);
    chk(release_ff, 8'h01);
    tick(1);
    chk(awake_ff, 8'h00);
    drp_tx_pend = 1'b0;
    drp_tx_map = '0;
  endtask
  // announcement holds the radio up until the response leaves
  task t_uda;
    pulse(uda_rx);
    tick(20);
    chk(awake_ff, 8'h01);
    pulse(udr_tx);
    tick(2);
    chk(awake_ff, 8'h00);
  endtask
  // contention reception in an open slot, sleep after last frame
  task t_pca_rx;
    pca_rx_expect = 1'b1;
    pca_open_map[3] = 1'b1;
    mas_idx = 8'h03;
    pulse(mas_start);
    tick(1);
    chk(awake_ff, 8'h01);
    pulse(pca_rx_last);
    tick(2);
    chk(awake_ff, 8'h00);
    pca_rx_expect = 1'b0;
  endtask
  // more frames flag: one only when neither last marker is set
  task t_more;
    for (int i = 0; i < 3; i++)
    begin
      {tx_last_blk, tx_last_pca} = 2'(i);
      pulse(tx_frame);
      chk(more_frames_ff, {7'h00, i == 0});
    end
  endtask
  // announce over two superframes, hibernate, come back
  task t_hib;
    pca_tx_pend = 1'b1;
    hib_req = 1'b1;
    hib_cnt_in = 8'h01;
    hib_dur_in = 8'h02;
    pulse(sf_start);
    hib_req = 1'b0;
    chk(hib_ie_ff, 8'h01);
    chk(hib_count_ff, 8'h01);
    chk(tim_ie_ff, 8'h01);
    pulse(sf_start);
    chk(hib_count_ff, 8'h00);
    chk(beacon_en_ff, 8'h01);
    pulse(sf_start);
    chk(beacon_en_ff, 8'h00);
    chk(awake_ff, 8'h00);
    chk(tim_ie_ff, 8'h00);
    pulse(sf_start);
    pulse(sf_start);
    chk(beacon_en_ff, 8'h01);
    // second round: no countdown, early exit on request
    hib_req = 1'b1;
    hib_cnt_in = 8'h00;
    pulse(sf_start);
    hib_req = 1'b0;
    chk(hib_ie_ff, 8'h01);
    pulse(sf_start);
    chk(beacon_en_ff, 8'h00);
    hib_exit = 1'b1;
    pulse(sf_start);
    hib_exit = 1'b0;
    chk(beacon_en_ff, 8'h01);
    pca_tx_pend = 1'b0;
  endtask
  // peer block towards us: awake from its guard, sleep after last frame
  task t_rx;
    drp_rx_map[7] = 1'b1;
    mas_guard_idx = 8'h07;
    mas_idx = 8'h07;
    pulse(mas_guard);
    chk(awake_ff, 8'h01);
    pulse(mas_start);
    pulse(drp_rx_last);
    tick(1);
    chk(awake_ff, 8'h00);
    drp_rx_map[7] = 1'b0;
  endtask
  // advertised availability: awake from guard of a listed, non-open mas
  task t_avail;
    pca_avail_adv = 1'b1;
    pca_rx_expect = 1'b1;
    pca_avail_map[9] = 1'b1;
    mas_guard_idx = 8'h09;
    mas_idx = 8'h09;
    pulse(mas_guard);
    chk(awake_ff, 8'h01);
    pulse(mas_start);
    pulse(pca_rx_last);
    tick(1);
    chk(awake_ff, 8'h00);
    {pca_avail_adv, pca_rx_expect} = 2'b00;
  endtask

  // cut a hang short well beyond the expected length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      stop_test;
    end
  end

  initial
  begin
    {sf_start, bp_guard, bp_end, mas_guard, mas_start, pca_avail_adv, drp_tx_pend, drp_tx_done} = '0;
    {drp_rx_last, pca_tx_pend, pca_rx_expect, pca_rx_last, uda_rx, udr_tx, tx_frame, tx_last_blk} = '0;
    {tx_last_pca, hib_req, hib_exit, peer_go, mas_guard_idx, mas_idx, hib_cnt_in, hib_dur_in} = '0;
    {drp_tx_map, drp_rx_map, pca_open_map, pca_avail_map} = '0;
    repeat (4) @(posedge clk);
    tick(1);
    chk(awake_ff, 8'h01);
    chk(beacon_en_ff, 8'h01);
    sys_rst = 1'b0;
    tick(2);
    t_wake;
    t_hdr;
    t_drp;
    t_uda;
    t_pca_rx;
    t_more;
    t_hib;
    t_rx;
    t_avail;
    stop_test;
  end
endmodule // msc_power_ctrl_tb
